/* File: inc/rspc_pkg.sv */
package rspc_pkg;
  localparam int SECTORS = 5;
  localparam int WORDS_PER_SECTOR = 16;
  localparam int WORD_ADDR_BITS = 4;
  localparam int SECTOR_SEL_BITS = 3;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] RAM_BASE = 12'h100;
  localparam logic [7:0] KEY_WRITE = 8'h5A;
  localparam logic [7:0] KEY_READ = 8'h69;
  localparam int KEY_LSB = 8;
  localparam logic [15:0] CTRL_RESET = 16'h6900;
  localparam logic [7:0] OFF_RESET = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h8F;
  localparam logic [2:0] SECTOR_HIGH = 3'h7;
  localparam logic [2:0] SECTOR_LOW_MAX = 3'h3;
  localparam int RAM_WIDTH = 16;

  typedef enum logic [1:0] {
    RSPC_ACTIVE = 2'b00,
    RSPC_RETAIN = 2'b01
  } rspc_mode_type;
endpackage

/* File: hdl/rspc_sector.sv */
module rspc_sector
  import rspc_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic reset, // synchronous reset
  input wire logic powerOff, // sector switched off
  input wire logic writeEnable, // word write strobe
  input wire logic [WORD_ADDR_BITS-1:0] wordIndex, // word inside sector
  input wire logic [RAM_WIDTH-1:0] writeData, // data to store
  output logic [RAM_WIDTH-1:0] readData // stored word or zero
);
  logic [RAM_WIDTH-1:0] memQ [WORDS_PER_SECTOR];
  logic [RAM_WIDTH-1:0] rawWord;

  assign rawWord = memQ[wordIndex];
  assign readData = powerOff ? '0 : rawWord; // see (R5)

  always_ff @(posedge clock)
  begin
    for (int i = 0; i < WORDS_PER_SECTOR; i++)
    begin
      // a dark sector keeps nothing: contents are wiped while off
      if (reset || powerOff)
        memQ[i] <= '0; // see (R6)
      else if (writeEnable && wordIndex == i[WORD_ADDR_BITS-1:0])
        memQ[i] <= writeData;
    end
  end
endmodule

/* File: hdl/ram_sector_power_control.sv */
// Functional notes
// (R1) control register changes only on full-width write with key 5Ah in bits 15:8
// (R2) byte writes or wrong key writes leave the register untouched
// (R3) key field always reads 69h
// (R4) each sector powers down independently from its own off bit
// (R5) reads from a switched-off sector return zero
// (R6) switching a sector off destroys its contents
// (R7) with cpu active, powered sectors are readable and writable anytime
// (R8) when cpu is off, ram goes to retention
// (R9) bit 7 controls sector 7, bits 3:0 sectors 3 to 0
// (R10) register resets to 6900h with all off bits clear
// (R11) software keeps stack sectors on for interrupts and low power
// (R12) software keeps sectors on while any word must hold data
// (R13) sector 7 off only when usb buffer unused
// (R14) writes to dark sectors dropped silently; bits 6:4 read zero
module ram_sector_power_control
  import rspc_pkg::*;
(
  input wire logic clock, // 100 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic cpuOff, // cpu switched off, from pin
  output logic [SECTORS-1:0] sectorPowerOff, // per-sector off control
  output logic ramRetention // ram in retention
);
  logic [7:0] offQ;
  logic [7:0] offD;
  logic cpuOffMeta;
  logic cpuOffSync;
  rspc_mode_type modeQ;
  logic [31:0] prdataQ;
  logic preadyQ;
  logic slverrQ;
  logic [SECTORS-1:0] sectorOffQ;
  logic retentionQ;

  // sector slot k maps to physical sectors 0..3 then 7
  function automatic logic [2:0] slotSector(input int k);
    return (k == SECTORS - 1) ? SECTOR_HIGH : k[2:0];
  endfunction

  function automatic logic slotHit(input logic [2:0] sel, input int k);
    return sel == slotSector(k);
  endfunction

  wire setupPhase = psel && !penable;
  wire ctrlHit = paddr == CTRL_OFFSET;
  wire ramHit = paddr[11:8] == RAM_BASE[11:8] && paddr[1:0] == 2'b00;
  wire [SECTOR_SEL_BITS-1:0] ramSector = paddr[7:5];
  // sector select sits in bits 7:5, so only bits 4:2 are free for the word: upper half of each sector is unreachable
  wire [WORD_ADDR_BITS-1:0] ramWord = {1'b0, paddr[4:2]};
  wire sectorExists = ramSector <= SECTOR_LOW_MAX || ramSector == SECTOR_HIGH;
  wire ramMapped = ramHit && sectorExists && ramWord < WORDS_PER_SECTOR;
  wire mapped = ctrlHit || ramMapped;
  wire wordWrite = pstrb[1:0] == 2'b11; // see (R2)
  wire keyOk = pwdata[15:KEY_LSB] == KEY_WRITE; // see (R1)
  wire ctrlWrite = setupPhase && pwrite && ctrlHit && wordWrite && keyOk; // see (R1)
  wire ramWrite = setupPhase && pwrite && ramMapped && wordWrite && modeQ == RSPC_ACTIVE; // see (R7)
  wire [15:0] ctrlRead = {KEY_READ, offQ & OFF_MASK}; // see (R3)

  logic [RAM_WIDTH-1:0] sectorData [SECTORS];
  logic [SECTORS-1:0] sectorSel;
  logic [RAM_WIDTH-1:0] ramRead;

  genvar g;
  generate
    for (g = 0; g < SECTORS; g++)
    begin : gSector
      wire offBit = offQ[slotSector(g)]; // see (R9)
      assign sectorSel[g] = slotHit(ramSector, g);
      rspc_sector uSector (
        .clock(clock),
        .reset(reset),
        .powerOff(offBit), // see (R4)
        .writeEnable(ramWrite && sectorSel[g] && !offBit), // see (R14)
        .wordIndex(ramWord),
        .writeData(pwdata[RAM_WIDTH-1:0]),
        .readData(sectorData[g])
      );
    end
  endgenerate

  always_comb
  begin
    ramRead = '0;
    for (int k = 0; k < SECTORS; k++)
    begin
      if (sectorSel[k])
        ramRead = sectorData[k];
    end
  end

  assign offD = ctrlWrite ? (pwdata[7:0] & OFF_MASK) : offQ; // see (R14)
  wire [31:0] readMux = ctrlHit ? {16'h0000, ctrlRead} : {16'h0000, ramRead};

  always_ff @(posedge clock)
  begin
    cpuOffMeta <= cpuOff;
    cpuOffSync <= cpuOffMeta;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      offQ <= CTRL_RESET[7:0]; // see (R10)
    else
      offQ <= offD;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      modeQ <= RSPC_ACTIVE;
    else
    begin
      case (cpuOffSync)
        1'b1: modeQ <= RSPC_RETAIN; // see (R8)
        1'b0: modeQ <= RSPC_ACTIVE;
        default: modeQ <= RSPC_ACTIVE;
      endcase
    end
  end

  // registered answer: ready in the first access cycle, no wait state, outputs flop-driven
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      preadyQ <= 1'b0;
      slverrQ <= 1'b0;
      prdataQ <= '0;
    end
    else
    begin
      preadyQ <= setupPhase;
      slverrQ <= setupPhase && !mapped;
      if (setupPhase && !pwrite && mapped)
        prdataQ <= readMux;
      else if (setupPhase)
        prdataQ <= '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sectorOffQ <= '0;
      retentionQ <= 1'b0;
    end
    else
    begin
      for (int k = 0; k < SECTORS; k++)
        sectorOffQ[k] <= offD[slotSector(k)]; // see (R4)
      retentionQ <= modeQ == RSPC_RETAIN; // see (R8)
    end
  end

  assign prdata = prdataQ;
  assign pready = preadyQ;
  assign pslverr = slverrQ;
  assign sectorPowerOff = sectorOffQ;
  assign ramRetention = retentionQ;
endmodule

/* File: verification/rspc_checker_properties.sv */
module rspc_checker
  import rspc_pkg::*;
(
  input wire logic clock, // clk
  input wire logic reset, // rst
  input wire logic psel, // in
  input wire logic penable, // in
  input wire logic pwrite, // in
  input wire logic [11:0] paddr, // in
  input wire logic [31:0] pwdata, // in
  input wire logic [3:0] pstrb, // in
  input wire logic [31:0] prdata, // in
  input wire logic pready, // in
  input wire logic pslverr, // in
  input wire logic cpuOff, // in
  input wire logic [SECTORS-1:0] sectorPowerOff, // in
  input wire logic ramRetention // in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire setup = psel && !penable;
  wire ctlSel = setup && paddr == CTRL_OFFSET;
  wire goodKey = ctlSel && pwrite && pstrb[1:0] == 2'b11 && pwdata[15:8] == KEY_WRITE;
  wire [4:0] newOff = {pwdata[7], pwdata[3:0]};
  wire [2:0] sec = paddr[7:5];
  wire [2:0] slot = sec == SECTOR_HIGH ? 3'h4 : sec;
  wire darkRead = setup && !pwrite && paddr[11:8] == 4'h1 && (sec <= SECTOR_LOW_MAX || sec == SECTOR_HIGH)
    && sectorPowerOff[slot];
  sequence s_asleep;
    cpuOff [*5];
  endsequence
  property p_answer; setup |=> pready; endproperty
  property p_single; pready |=> !pready; endproperty
  property p_key; goodKey |=> sectorPowerOff == $past(newOff); endproperty
  property p_hold; !goodKey |=> $stable(sectorPowerOff); endproperty
  property p_keyread; ctlSel && !pwrite |=> prdata[15:8] == KEY_READ && prdata[6:4] == 3'h0; endproperty
  property p_dark; darkRead |=> prdata == 32'h0; endproperty
  property p_retain; s_asleep |-> ramRetention; endproperty
  property p_reset; $past(reset) |-> sectorPowerOff == 5'h0; endproperty
  a_answer: assert property (p_answer) else $error("ready missing");
  a_single: assert property (p_single) else $error("ready too long");
  a_key: assert property (p_key) else $error("keyed write lost");
  a_hold: assert property (p_hold) else $error("control changed");
  a_keyread: assert property (p_keyread) else $error("key field wrong");
  a_dark: assert property (p_dark) else $error("dark sector data");
  a_retain: assert property (p_retain) else $error("no retention");
  a_reset: assert property (p_reset) else $error("reset value wrong");
endmodule
bind ram_sector_power_control rspc_checker u_checker (.*);

/* File: verification/rspc_cpu.sv */
module rspc_cpu
(
  input wire logic clock, // bus clock
  output logic psel, // select
  output logic penable, // access phase
  output logic pwrite, // direction
  output logic [11:0] paddr, // address
  output logic [31:0] pwdata, // write data
  output logic [3:0] pstrb, // strobes
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr // error
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // no stack or usb buffer lives here, so any sector may go dark
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] r, output logic e);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
endmodule

/* File: verification/ram_sector_power_control_test.sv */
module ram_sector_power_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rspc_pkg::*;
  logic clock = 0, reset = 1, cpuOff = 0, psel, penable, pwrite, pready, pslverr, ramRetention, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, s, w;
  logic [3:0] pstrb;
  logic [SECTORS-1:0] sectorPowerOff;
  logic [15:0] mem [8][8];
  logic [7:0] off = 8'h00;
  logic [2:0] sc;
  int miscompares = 0, n_tests = 0, seed = 32'h862E4160;
  ram_sector_power_control u_dut (.*);
  rspc_cpu u_cpu (.*);
  always #5 clock = ~clock;
  task chk(input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task ctl(input logic [7:0] key, input logic [3:0] st);
    u_cpu.xfer(1'b1, CTRL_OFFSET, {16'h0, key, w[7:0]}, st, r, e);
    if (key == KEY_WRITE && st[1:0] == 2'b11)
    begin
      for (int k = 0; k < 8; k++)
        if (w[k] && OFF_MASK[k])
          mem[k] = '{default: 16'h0};
      off = w[7:0] & OFF_MASK;
    end
  endtask
  task ram(input logic wr, input logic [15:0] d);
    u_cpu.xfer(wr, RAM_BASE + {sc, w[2:0], 2'b00}, {16'h0, d}, 4'hF, r, e);
    if (wr && !off[sc] && !cpuOff)
      mem[sc][w[2:0]] = d;
    if (!wr)
      chk(r, {16'h0, off[sc] ? 16'h0 : mem[sc][w[2:0]]});
  endtask
  initial
  begin
    foreach (mem[i, j])
      mem[i][j] = 16'h0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    repeat (300)
    begin
      s = $random(seed);
      w = $random(seed);
      sc = s[2] ? SECTOR_HIGH : {1'b0, s[1:0]};
      u_cpu.xfer(1'b0, CTRL_OFFSET, 32'h0, 4'h0, r, e);
      chk(r, {16'h0, KEY_READ, off});
      chk({27'h0, sectorPowerOff}, {27'h0, off[7], off[3:0]});
      if (s[5:4] == 2'b00)
        ctl(s[3] ? KEY_WRITE : w[15:8], s[6] ? 4'hF : {2'b00, s[7], !s[7]});
      else
        ram(s[4], w[31:16]);
      cpuOff <= &s[10:8];
      repeat (5) @(posedge clock);
      #1;
      chk({31'h0, ramRetention}, {31'h0, cpuOff});
    end
    u_cpu.xfer(1'b0, 12'h200, 32'h0, 4'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    wrap_up;
  end
  initial
  begin
    #100000;
    miscompares++;
    wrap_up;
  end
endmodule
